// File: core/cptg_top.sv
/*
 * counter pulse train generator: apb registers, gate logic, output counter
 * and the adjacent gating counter used for finite trains.
 * assumes timebase and gate inputs synchronous to sys_clk; an edge of the
 * selected timebase is one count.
 */
// Local design decisions: the register addresses and the APB interface to the registers.
// Summary of operation
// - toggled output inverts at each terminal count
// - pulsed output gives a one-timebase-cycle pulse at terminal count
// - idle level low for positive polarity, high for negative
// - phase one runs from counting start to first rising edge
// - phase two runs from rising to falling edge, the pulse
// - continuous train repeats phase one and two until stopped; with an edge gate or retrigger the code waits in ST_WAIT after each pulse
// - period is phase one plus phase two
// - duty cycle is phase two over period
// - counts internal or external timebase, optional gate qualifies
// - single mode: delay, one pulse, then stop
// - configuration held apart; start begins at once without reconfiguring
// - pulse count zero gives continuous train, nonzero finite
// - zero phase lengths forced to one, never a constant level; a continuous train with both phases at one holds the pulsed pin high
// - finite train: output counter level-gated by second counter pulse
// - finite train length limited by counter width
// - gating counter triggers on one edge or every edge
// - start may lag by up to one timebase period
// - retriggerable mode restarts generation on each gate trigger; the code ignores a rise in phase two, or in phase one off a timebase edge
// - gate change after a timebase edge counts from the next edge
`timescale 1ns/1ps
`default_nettype none

module cptg_top
	import cptg_pkg::*;
#(
	parameter int CW = cptg_pkg::CPTG_CW
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire cptg_pkg::cptg_apb_req_t apb_req,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   int_timebase,
	input  wire logic                   ext_source,
	input  wire logic                   gate_in,
	input  wire logic                   fin_gate_in,
	output logic                        pulse_out,
	output logic                        terminal_count,
	output logic                        running
);
	import cptg_pkg::*;

	logic [31:0]     ctrl;
	logic [CW-1:0]   ph1_len;
	logic [CW-1:0]   ph2_len;
	logic [CW-1:0]   npulse;
	cptg_state_t     state;
	logic [CW-1:0]   count;
	logic            out_lvl;
	logic            src_q;
	logic            tb_sel;
	logic            tb_edge;
	logic            gate_q;
	logic            fg_q;
	logic            start_pend;
	logic            gate_pend;
	logic            armed;
	logic            fin_run;
	logic [CW-1:0]   fin_cnt;
	logic            gate_ok;
	logic            gate_rise;
	logic            fin_rise;
	logic            wr_en;
	logic            rd_en;
	logic            tc_now;
	logic            mapped;

	// apb decode; a read or write completes in its first access cycle
	assign wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite & ce;
	assign rd_en   = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ce;

	// decoding used by the error answer only; the read path decodes paddr itself
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFF_CTRL) || (a == OFF_PH1) || (a == OFF_PH2) ||
		            (a == OFF_NPULSE) || (a == OFF_CMD) || (a == OFF_STAT);
	endfunction

	// zero phases are raised to one so the toggled output always moves
	function automatic logic [CW-1:0] at_least_one(input logic [31:0] v);
		at_least_one = (v[CW-1:0] == '0) ? CW'(1) : v[CW-1:0];
	endfunction

	assign mapped = is_mapped(apb_req.paddr);

	// configuration registers: held while idle or running, start is separate
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl    <= RST_CTRL;
			ph1_len <= CW'(1);
			ph2_len <= CW'(1);
			npulse  <= '0;
		end else if (wr_en) begin
			case (apb_req.paddr)
				OFF_CTRL:   ctrl    <= apb_req.pwdata;
				OFF_PH1:    ph1_len <= at_least_one(apb_req.pwdata);
				OFF_PH2:    ph2_len <= at_least_one(apb_req.pwdata);
				OFF_NPULSE: npulse  <= apb_req.pwdata[CW-1:0];
				default:    ;
			endcase
		end
	end

	// apb answer registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= apb_req.psel & ~apb_req.penable;
			pslverr <= apb_req.psel & ~apb_req.penable & ~mapped;
			prdata  <= 32'h0;
			if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
				case (apb_req.paddr)
					OFF_CTRL:   prdata <= ctrl;
					OFF_PH1:    prdata <= 32'(ph1_len);
					OFF_PH2:    prdata <= 32'(ph2_len);
					OFF_NPULSE: prdata <= 32'(npulse);
					OFF_STAT:   prdata <= {28'h0, fin_run, out_lvl,
					                       state == ST_WAIT, state != ST_IDLE};
					default:    prdata <= 32'h0;
				endcase
			end
		end
	end

	// timebase selection and rising-edge detect on the chosen source
	assign tb_sel    = ctrl[CTRL_EXTSRC] ? ext_source : int_timebase;
	assign tb_edge   = tb_sel & ~src_q;
	assign gate_rise = gate_in & ~gate_q;
	assign fin_rise  = fin_gate_in & ~fg_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			src_q  <= 1'b0;
			gate_q <= 1'b0;
			fg_q   <= 1'b0;
		end else if (ce) begin
			src_q  <= tb_sel;
			gate_q <= gate_in;
			fg_q   <= fin_gate_in;
		end
	end

	// adjacent gating counter: a delayed pulse long enough for npulse periods
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fin_run <= 1'b0;
			fin_cnt <= '0;
			armed   <= 1'b0;
		end else if (ce) begin
			if (wr_en && apb_req.paddr == OFF_CMD && apb_req.pwdata[CMD_STOP]) begin
				fin_run <= 1'b0;
				armed   <= 1'b0;
			end else if (wr_en && apb_req.paddr == OFF_CMD &&
			             apb_req.pwdata[CMD_START] && npulse != '0) begin
				armed <= 1'b1;
			end else if (armed && fin_rise && !fin_run) begin
				fin_run <= 1'b1;
				fin_cnt <= npulse;
				armed   <= ctrl[CTRL_FGMULT];
			end else if (fin_run && tb_edge && state == ST_PH2 && tc_now) begin
				if (fin_cnt == CW'(1))
					fin_run <= 1'b0;
				fin_cnt <= fin_cnt - CW'(1);
			end
		end
	end

	// gate qualification for the output counter
	always_comb begin
		if (npulse != '0)
			gate_ok = fin_run;
		else case (ctrl[CTRL_GMODE +: 2])
			GM_LEVEL: gate_ok = gate_in;
			default:  gate_ok = 1'b1;
		endcase
	end

	assign tc_now = (count == CW'(1));

	// start requests, held until the next timebase edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			start_pend <= 1'b0;
			gate_pend  <= 1'b0;
		end else if (ce) begin
			if (wr_en && apb_req.paddr == OFF_CMD && apb_req.pwdata[CMD_STOP])
				start_pend <= 1'b0;
			else if (wr_en && apb_req.paddr == OFF_CMD && apb_req.pwdata[CMD_START])
				start_pend <= 1'b1;
			else if (tb_edge)
				start_pend <= 1'b0;
			if (gate_rise && ctrl[CTRL_GMODE +: 2] == GM_EDGE)
				gate_pend <= 1'b1;
			else if (tb_edge || state == ST_IDLE)
				gate_pend <= 1'b0;
		end
	end

	// generator state machine and count register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state   <= ST_IDLE;
			count   <= '0;
			out_lvl <= 1'b0;
			terminal_count <= 1'b0;
		end else if (ce) begin
			if (tb_edge)
				terminal_count <= 1'b0;
			if (wr_en && apb_req.paddr == OFF_CMD && apb_req.pwdata[CMD_STOP]) begin
				state   <= ST_IDLE;
				out_lvl <= 1'b0;
				terminal_count <= 1'b0;
			end else if (tb_edge) begin
				case (state)
					ST_IDLE: if (start_pend) begin
						// counting starts only on a timebase edge
						state <= (ctrl[CTRL_GMODE +: 2] == GM_EDGE) ? ST_WAIT : ST_PH1;
						count <= ph1_len;
						out_lvl <= 1'b0;
					end
					ST_WAIT: if (gate_pend || gate_rise) begin
						state <= ST_PH1;
						count <= ph1_len;
					end
					ST_PH1: if (gate_ok) begin
						if (ctrl[CTRL_RETRIG] && gate_rise)
							count <= ph1_len;
						else if (tc_now) begin
							state   <= ST_PH2;
							count   <= ph2_len;
							out_lvl <= 1'b1;
							terminal_count <= 1'b1;
						end else
							count <= count - CW'(1);
					end
					ST_PH2: if (gate_ok || fin_run) begin
						if (tc_now) begin
							out_lvl <= 1'b0;
							terminal_count <= 1'b1;
							count <= ph1_len;
							if (ctrl[CTRL_SINGLE])
								state <= ST_IDLE;
							else if (ctrl[CTRL_RETRIG] || ctrl[CTRL_GMODE +: 2] == GM_EDGE)
								state <= ST_WAIT;
							else
								state <= ST_PH1;
						end else
							count <= count - CW'(1);
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// output pin: toggled shows the phase level, pulsed shows the tc pulse
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pulse_out <= 1'b0;
			running   <= 1'b0;
		end else if (ce) begin
			pulse_out <= (ctrl[CTRL_TOGGLE] ? out_lvl : terminal_count)
			             ^ ctrl[CTRL_NEG];
			running   <= (state != ST_IDLE);
		end
	end

	// assertions
	a_phase_min: assert property (@(posedge sys_clk) disable iff (rst)
		ph1_len != '0 && ph2_len != '0)
		else $error("phase length reached zero");
	a_idle_level: assert property (@(posedge sys_clk) disable iff (rst)
		ce && $past(ce) && $past(state) == ST_IDLE && $past(out_lvl) == 1'b0
		&& $past(ctrl[CTRL_TOGGLE]) && $stable(ctrl)
		|-> pulse_out == ctrl[CTRL_NEG])
		else $error("idle output level wrong");
	a_toggle_rise: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == ST_PH1 && tb_edge && gate_ok && tc_now && !ctrl[CTRL_RETRIG]
		&& !(wr_en && apb_req.paddr == OFF_CMD)
		|=> out_lvl && state == ST_PH2)
		else $error("no rise at end of first phase");
	a_toggle_fall: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == ST_PH2 && tb_edge && gate_ok && tc_now
		&& !(wr_en && apb_req.paddr == OFF_CMD) |=> !out_lvl)
		else $error("no fall at end of pulse");
	a_tc_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		ce && terminal_count && tb_edge
		&& !(tc_now && (state == ST_PH1 || state == ST_PH2))
		|=> !terminal_count)
		else $error("terminal count held past one timebase cycle");
	a_single_stop: assert property (@(posedge sys_clk) disable iff (rst)
		ce && ctrl[CTRL_SINGLE] && state == ST_PH2 && tb_edge && gate_ok && tc_now
		|=> state == ST_IDLE)
		else $error("single pulse did not stop");
	a_cont_repeat: assert property (@(posedge sys_clk) disable iff (rst)
		ce && !ctrl[CTRL_SINGLE] && !ctrl[CTRL_RETRIG] && ctrl[CTRL_GMODE +: 2] != GM_EDGE
		&& state == ST_PH2 && tb_edge && gate_ok && tc_now
		&& !(wr_en && apb_req.paddr == OFF_CMD) |=> state == ST_PH1 && count == ph1_len)
		else $error("continuous train did not repeat");
	a_start_edge: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == ST_IDLE && !tb_edge |=> state == ST_IDLE)
		else $error("started without a timebase edge");
	a_finite_gate: assert property (@(posedge sys_clk) disable iff (rst)
		ce && npulse != '0 && !fin_run && state == ST_PH1 |=> $stable(count))
		else $error("finite train counted without gate");
	c_single: cover property (@(posedge sys_clk) ctrl[CTRL_SINGLE] && state == ST_PH2);
	c_finite: cover property (@(posedge sys_clk) fin_run && state == ST_PH2);
	c_retrig: cover property (@(posedge sys_clk) ctrl[CTRL_RETRIG] && state == ST_WAIT);
	c_pulsed: cover property (@(posedge sys_clk) !ctrl[CTRL_TOGGLE] && terminal_count);
	c_extsrc: cover property (@(posedge sys_clk) ctrl[CTRL_EXTSRC] && state == ST_PH2);

	// a stop command wins over every pending edge, so out_lvl is back
	// at its rest level one cycle later whatever the phase was, the registered pin one cycle after that
	a_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
		ce && wr_en && apb_req.paddr == OFF_CMD && apb_req.pwdata[CMD_STOP]
		|=> state == ST_IDLE && !out_lvl)
		else $error("stop did not return to idle");

	// the end of phase one must reload the pulse width, not keep counting;
	// a stale count here would stretch the period silently
	a_period_load: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == ST_PH1 && tb_edge && gate_ok && tc_now && !ctrl[CTRL_RETRIG]
		&& !(wr_en && apb_req.paddr == OFF_CMD)
		|=> count == ph2_len)
		else $error("pulse width not loaded");

	// a gate rise that meets a timebase edge in phase one restarts the delay like a one-shot
	a_retrig_reload: assert property (@(posedge sys_clk) disable iff (rst)
		ce && state == ST_PH1 && tb_edge && gate_ok && ctrl[CTRL_RETRIG] && gate_rise
		&& !(wr_en && apb_req.paddr == OFF_CMD)
		|=> count == ph1_len && state == ST_PH1)
		else $error("retrigger did not reload delay");

	// the gating counter drops its gate after the last requested pulse,
	// otherwise a finite train would run on as a continuous one
	a_fin_end: assert property (@(posedge sys_clk) disable iff (rst)
		ce && fin_run && fin_cnt == CW'(1) && tb_edge && state == ST_PH2 && tc_now
		&& !(wr_en && apb_req.paddr == OFF_CMD)
		|=> !fin_run)
		else $error("finite gate outlived its pulse count");

	// a low level gate freezes the count in the delay phase
	a_gate_hold: assert property (@(posedge sys_clk) disable iff (rst)
		ce && npulse == '0 && ctrl[CTRL_GMODE +: 2] == GM_LEVEL && !gate_in
		&& state == ST_PH1 |=> $stable(count))
		else $error("counted while level gate low");

	// limitation: a train with both phases at one edge gives back-to-back
	// terminal counts, so the pulsed pin then stays high for the whole train

endmodule

`default_nettype wire

// File: core/cptg_pkg.sv
/*
 * package for the counter pulse train generator: register map, field
 * positions, reset values and state encodings.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
package cptg_pkg;

	localparam int CPTG_CW = 24;            // counter width, 24-bit variant

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_PH1    = 8'h04;
	localparam logic [7:0] OFF_PH2    = 8'h08;
	localparam logic [7:0] OFF_NPULSE = 8'h0c;
	localparam logic [7:0] OFF_CMD    = 8'h10;
	localparam logic [7:0] OFF_STAT   = 8'h14;

	// ctrl field positions
	localparam int CTRL_TOGGLE = 0;         // 1 toggled, 0 pulsed
	localparam int CTRL_NEG    = 1;         // 1 negative polarity
	localparam int CTRL_SINGLE = 2;         // 1 single delayed pulse
	localparam int CTRL_EXTSRC = 3;         // 1 count external source
	localparam int CTRL_GMODE  = 4;         // 2 bits gate mode
	localparam int CTRL_RETRIG = 6;         // retriggerable
	localparam int CTRL_FGMULT = 7;         // finite gate, multiple edges

	// gate modes
	localparam logic [1:0] GM_NONE  = 2'h0;
	localparam logic [1:0] GM_LEVEL = 2'h1;
	localparam logic [1:0] GM_EDGE  = 2'h2;

	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP  = 1;

	localparam logic [31:0] RST_CTRL  = 32'h0000_0001;
	localparam logic [31:0] RST_PHASE = 32'h0000_0001;

	// generator states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_PH1  = 4'h4,
		ST_PH2  = 4'h8
	} cptg_state_t;

	// apb request carrier
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cptg_apb_req_t;

endpackage

// File: testbench/cptg_far_model.sv
/*
 * far-side model: free-running internal and external timebases, plus a
 * listener that measures the high and low spans of the output pin.
 * assumes pulse_out is registered on sys_clk and reset drives it low.
 */
`timescale 1ns/1ps
`default_nettype none

module cptg_far_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        pulse_out,
	output logic             int_timebase,
	output logic             ext_source,
	output logic [15:0]      n_rise,
	output logic [15:0]      hi_len,
	output logic [15:0]      lo_len
);
	logic [3:0]  div;
	logic [15:0] run;
	logic        last;

	// one divider gives both sources: internal every 4 cycles, external every 6
	always_ff @(posedge sys_clk) begin
		div <= (rst || div == 4'hb) ? 4'h0 : div + 4'h1;
	end
	assign int_timebase = div[1];
	assign ext_source   = (div >= 4'h3 && div < 4'h6) || div >= 4'h9;

	// span of each level in sys_clk cycles; a stop truncates the last one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last   <= 1'b0;
			run    <= 16'h1;
			n_rise <= 16'h0;
			hi_len <= 16'h0;
			lo_len <= 16'h0;
		end else if (pulse_out !== last) begin
			last <= pulse_out;
			run  <= 16'h1;
			if (last) hi_len <= run;
			else lo_len <= run;
			if (!last) n_rise <= n_rise + 16'h1;
		end else begin
			run <= run + 16'h1;
		end
	end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
/*
 * self-checking bench: apb register access and pulse shape checks.
 * assumes the far-side model supplies a timebase edge every 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import cptg_pkg::*;
	logic          sys_clk = 1'b0;
	logic          rst = 1'b1;
	logic          gate_in = 1'b0;
	logic          fin_gate_in = 1'b0;
	cptg_apb_req_t req = '0;
	logic [31:0]   prdata;
	logic          pready, pslverr, pulse_out, terminal_count, running;
	logic          int_timebase, ext_source;
	logic [15:0]   n_rise, hi_len, lo_len, r0;
	logic [31:0]   rd;
	logic          e;
	int            n_fail = 0;
	int            cmp_count = 0;

	always #4 sys_clk = ~sys_clk;

	cptg_top dut_u (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.int_timebase(int_timebase), .ext_source(ext_source), .gate_in(gate_in),
		.fin_gate_in(fin_gate_in), .pulse_out(pulse_out),
		.terminal_count(terminal_count), .running(running));

	cptg_far_model far_u (.sys_clk(sys_clk), .rst(rst), .pulse_out(pulse_out),
		.int_timebase(int_timebase), .ext_source(ext_source), .n_rise(n_rise),
		.hi_len(hi_len), .lo_len(lo_len));

	task automatic end_of_test;
		if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, entered just after a rising edge; waits for pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		t = 0;
		do begin
			@(posedge sys_clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		e = pslverr;
		if (t >= 20) begin
			n_fail++;
			end_of_test();
		end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic fin_pulse;
		fin_gate_in <= 1'b1;
		cyc(1);
		fin_gate_in <= 1'b0;
	endtask

	// watchdog: the whole sequence needs under 3000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		cyc(10);
		rst <= 1'b0;
		// reset values, a refused address, a write-only place
		rdchk(OFF_CTRL, RST_CTRL);
		rdchk(OFF_PH1, RST_PHASE);
		rdchk(OFF_PH2, RST_PHASE);
		rdchk(OFF_NPULSE, 32'h0);
		rdchk(OFF_STAT, 32'h0);
		chk({31'h0, pulse_out}, 32'h0);
		rdchk(OFF_CMD, 32'h0);
		xfer(1'b0, 8'h18, 32'h0);
		chk({rd[30:0], e}, 32'h1);
		wr(OFF_PH1, 32'h0);
		rdchk(OFF_PH1, 32'h1);
		// continuous toggled train, configured well before start
		wr(OFF_PH1, 32'h3);
		wr(OFF_PH2, 32'h2);
		cyc(20);
		chk({31'h0, pulse_out}, 32'h0);
		r0 = n_rise;
		wr(OFF_CMD, 32'h1);
		cyc(120);
		chk({16'h0, hi_len}, 32'h8);
		chk({16'h0, lo_len}, 32'hc);
		chk({31'h0, (n_rise - r0) >= 16'h5}, 32'h1);
		chk({31'h0, running}, 32'h1);
		wr(OFF_CMD, 32'h2);
		cyc(2);
		chk({30'h0, running, pulse_out}, 32'h0);
		// negative polarity rests high
		wr(OFF_CTRL, 32'h3);
		cyc(4);
		chk({31'h0, pulse_out}, 32'h1);
		// pulsed: one timebase period high
		wr(OFF_CTRL, 32'h0);
		wr(OFF_PH1, 32'h2);
		wr(OFF_PH2, 32'h2);
		wr(OFF_CMD, 32'h1);
		cyc(100);
		chk({16'h0, hi_len}, 32'h4);
		wr(OFF_CMD, 32'h2);
		// single delayed pulse then stop
		wr(OFF_CTRL, 32'h5);
		wr(OFF_PH2, 32'h3);
		r0 = n_rise;
		wr(OFF_CMD, 32'h1);
		cyc(150);
		chk({16'h0, n_rise - r0}, 32'h1);
		chk({16'h0, hi_len}, 32'hc);
		chk({31'h0, running}, 32'h0);
		// external source, 6 cycles an edge
		wr(OFF_CTRL, 32'h9);
		wr(OFF_PH2, 32'h2);
		wr(OFF_CMD, 32'h1);
		cyc(150);
		chk({hi_len, lo_len}, 32'h000c_000c);
		wr(OFF_CMD, 32'h2);
		// level gate holds the output off until high
		wr(OFF_CTRL, 32'h11);
		r0 = n_rise;
		wr(OFF_CMD, 32'h1);
		cyc(60);
		chk({16'h0, n_rise - r0}, 32'h0);
		gate_in <= 1'b1;
		cyc(100);
		chk({31'h0, n_rise != r0}, 32'h1);
		wr(OFF_CMD, 32'h2);
		gate_in <= 1'b0;
		// finite train of three, one and then every trigger edge
		wr(OFF_CTRL, 32'h1);
		wr(OFF_PH1, 32'h1);
		wr(OFF_PH2, 32'h1);
		wr(OFF_NPULSE, 32'h3);
		r0 = n_rise;
		wr(OFF_CMD, 32'h1);
		cyc(60);
		chk({16'h0, n_rise - r0}, 32'h0);
		fin_pulse();
		cyc(200);
		chk({16'h0, n_rise - r0}, 32'h3);
		wr(OFF_CMD, 32'h2);
		wr(OFF_CTRL, 32'h81);
		r0 = n_rise;
		wr(OFF_CMD, 32'h1);
		fin_pulse();
		cyc(150);
		fin_pulse();
		cyc(150);
		chk({16'h0, n_rise - r0}, 32'h6);
		wr(OFF_CMD, 32'h2);
		end_of_test();
	end
endmodule

`default_nettype wire
